//--- common/cifr_pkg.sv
// Purpose: Shared constants and types for the CPU interrupt flag registers
// Assumes: 8-bit register port, byte offsets as printed
// Notes: Source order in cifr_src_t is used for request and vector lines
package cifr_pkg;
    localparam logic [7:0] CIFR_OFS_FIRST = 8'h88;
    localparam logic [7:0] CIFR_OFS_CRYPTO = 8'h98;
    localparam logic [7:0] CIFR_OFS_RADIO = 8'h9b;
    localparam logic [7:0] CIFR_OFS_ENABLE = 8'ha0;
    localparam logic [7:0] CIFR_OFS_ISTAT = 8'ha1;
    localparam logic [7:0] CIFR_OFS_IMASK = 8'ha2;
    localparam logic [7:0] CIFR_RST_FIRST = 8'h05;
    localparam logic [7:0] CIFR_RST_CRYPTO = 8'h00;
    localparam logic [7:0] CIFR_RST_RADIO = 8'h00;
    localparam logic [7:0] CIFR_RST_ENABLE = 8'h00;
    localparam logic [7:0] CIFR_RST_ISTAT = 8'h00;
    localparam logic [7:0] CIFR_RST_IMASK = 8'h00;
    localparam int CIFR_BIT_SERIAL_B = 7;
    localparam int CIFR_BIT_CONVERTER = 5;
    localparam int CIFR_BIT_SERIAL_A = 3;
    localparam int CIFR_BIT_RES_HI = 2;
    localparam int CIFR_BIT_RADIO_TXRX = 1;
    localparam int CIFR_BIT_RES_LO = 0;
    localparam int CIFR_BIT_PAIR_HI = 1;
    localparam int CIFR_BIT_PAIR_LO = 0;
    localparam int CIFR_NSRC = 6;
    // Source index: 0 serial_b, 1 converter, 2 serial_a, 3 radio_txrx,
    // 4 crypto pair, 5 radio general pair
    localparam int CIFR_SRC_SERIAL_B = 0;
    localparam int CIFR_SRC_CONVERTER = 1;
    localparam int CIFR_SRC_SERIAL_A = 2;
    localparam int CIFR_SRC_RADIO_TXRX = 3;
    localparam int CIFR_SRC_CRYPTO = 4;
    localparam int CIFR_SRC_RADIO_GEN = 5;
    typedef logic [CIFR_NSRC-1:0] cifr_src_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cifr_bus_req_t;
endpackage

//--- rtl/cifr_flags.sv
// Purpose: CPU interrupt flag registers with vector-driven clearing
// Assumes: Event and vector pulses come from sys_clk logic, one cycle long
// Notes: Enable, status and mask registers sit beside the three flag regs
// How it works
// - Bit 7 of first register sets on serial B/audio rx, clears on vector.
// - Bit 5 of first register sets on converter event, clears on vector.
// - Bit 3 of first register sets on serial A rx, clears on vector.
// - Bit 1 of first register sets on radio txrx done, clears on vector.
// - First register bits 2 and 0 reset to one; software writes ones.
// - Flags read one while pending; non-reserved flags reset to zero.
// - Crypto request sets both crypto pair bits together.
// - Radio general request sets both radio pair bits together.
// - Software setting either bit of a pair raises a request.
// - Unused flag register bits reset to zero and stay readable and writable.
// - Flags set on their source regardless of enable.
// - Enabled pending flag raises vector request on next cycle.
// - Module flag clear re-asserts CPU flag if module still pending.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module cifr_flags
    import cifr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire cifr_pkg::cifr_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    // Peripheral event pulses
    input wire cifr_pkg::cifr_src_t src_event,
    // Module flag cleared while module still has enabled pending flags
    input wire cifr_pkg::cifr_src_t module_clear_pending,
    // CPU vectoring: one-hot acknowledge of the source being vectored
    input wire cifr_pkg::cifr_src_t vector_ack,
    output cifr_pkg::cifr_src_t irq_request,
    output logic irq
);
    import cifr_pkg::*;

    logic [7:0] flags_first;
    logic [7:0] flags_crypto;
    logic [7:0] flags_radio;
    logic [7:0] enable;
    logic [7:0] istat;
    logic [7:0] imask;
    cifr_src_t set_src;
    cifr_src_t pending;
    logic wr_first;
    logic wr_crypto;
    logic wr_radio;

    // Re-assertion after a module flag clear looks like a fresh event
    assign set_src = src_event | module_clear_pending;

    assign wr_first = bus_req.wr && bus_req.addr == CIFR_OFS_FIRST;
    assign wr_crypto = bus_req.wr && bus_req.addr == CIFR_OFS_CRYPTO;
    assign wr_radio = bus_req.wr && bus_req.addr == CIFR_OFS_RADIO;

    // Set wins over a same-cycle write or vector clear
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            flags_first <= CIFR_RST_FIRST;
        end
        else
        begin
            if (wr_first)
            begin
                flags_first <= bus_req.wdata;
            end
            else
            begin
                if (vector_ack[CIFR_SRC_SERIAL_B])
                    flags_first[CIFR_BIT_SERIAL_B] <= 1'b0;
                if (vector_ack[CIFR_SRC_CONVERTER])
                    flags_first[CIFR_BIT_CONVERTER] <= 1'b0;
                if (vector_ack[CIFR_SRC_SERIAL_A])
                    flags_first[CIFR_BIT_SERIAL_A] <= 1'b0;
                if (vector_ack[CIFR_SRC_RADIO_TXRX])
                    flags_first[CIFR_BIT_RADIO_TXRX] <= 1'b0;
            end
            if (set_src[CIFR_SRC_SERIAL_B])
                flags_first[CIFR_BIT_SERIAL_B] <= 1'b1;
            if (set_src[CIFR_SRC_CONVERTER])
                flags_first[CIFR_BIT_CONVERTER] <= 1'b1;
            if (set_src[CIFR_SRC_SERIAL_A])
                flags_first[CIFR_BIT_SERIAL_A] <= 1'b1;
            if (set_src[CIFR_SRC_RADIO_TXRX])
                flags_first[CIFR_BIT_RADIO_TXRX] <= 1'b1;
        end
    end

    // Pairs are not cleared on vector; software clears them
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            flags_crypto <= CIFR_RST_CRYPTO;
        end
        else
        begin
            if (wr_crypto)
                flags_crypto <= bus_req.wdata;
            if (set_src[CIFR_SRC_CRYPTO])
            begin
                flags_crypto[CIFR_BIT_PAIR_HI] <= 1'b1;
                flags_crypto[CIFR_BIT_PAIR_LO] <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            flags_radio <= CIFR_RST_RADIO;
        end
        else
        begin
            if (wr_radio)
                flags_radio <= bus_req.wdata;
            if (set_src[CIFR_SRC_RADIO_GEN])
            begin
                flags_radio[CIFR_BIT_PAIR_HI] <= 1'b1;
                flags_radio[CIFR_BIT_PAIR_LO] <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            enable <= CIFR_RST_ENABLE;
        else if (bus_req.wr && bus_req.addr == CIFR_OFS_ENABLE)
            enable <= bus_req.wdata;
    end

    always_comb
    begin
        pending[CIFR_SRC_SERIAL_B] = flags_first[CIFR_BIT_SERIAL_B];
        pending[CIFR_SRC_CONVERTER] = flags_first[CIFR_BIT_CONVERTER];
        pending[CIFR_SRC_SERIAL_A] = flags_first[CIFR_BIT_SERIAL_A];
        pending[CIFR_SRC_RADIO_TXRX] = flags_first[CIFR_BIT_RADIO_TXRX];
        pending[CIFR_SRC_CRYPTO] = flags_crypto[CIFR_BIT_PAIR_HI]
            | flags_crypto[CIFR_BIT_PAIR_LO];
        pending[CIFR_SRC_RADIO_GEN] = flags_radio[CIFR_BIT_PAIR_HI]
            | flags_radio[CIFR_BIT_PAIR_LO];
    end

    // Registered request: one cycle after the flag is seen
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            irq_request <= '0;
        else
            irq_request <= pending & enable[CIFR_NSRC-1:0];
    end

    // Sticky status of source events, write one to clear, set wins
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            istat <= CIFR_RST_ISTAT;
        end
        else
        begin
            for (int i = 0; i < CIFR_NSRC; i++)
            begin
                if (set_src[i])
                    istat[i] <= 1'b1;
                else if (bus_req.wr && bus_req.addr == CIFR_OFS_ISTAT
                         && bus_req.wdata[i])
                    istat[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            imask <= CIFR_RST_IMASK;
        else if (bus_req.wr && bus_req.addr == CIFR_OFS_IMASK)
            imask <= bus_req.wdata & 8'h3f;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(istat & imask);
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            bus_rdata <= 8'h00;
        end
        else if (bus_req.rd)
        begin
            case (bus_req.addr)
                CIFR_OFS_FIRST: bus_rdata <= flags_first;
                CIFR_OFS_CRYPTO: bus_rdata <= flags_crypto;
                CIFR_OFS_RADIO: bus_rdata <= flags_radio;
                CIFR_OFS_ENABLE: bus_rdata <= enable;
                CIFR_OFS_ISTAT: bus_rdata <= istat;
                CIFR_OFS_IMASK: bus_rdata <= imask;
                default: bus_rdata <= 8'h00;
            endcase
        end
        else
        begin
            bus_rdata <= 8'h00;
        end
    end
endmodule

//--- sim/cifr_monitor.sv
// Purpose: Port assertions for cifr_flags
// Assumes: One-hot vector_ack
// Notes: Shadows the enable and mask registers
`timescale 1ns/1ps
module cifr_monitor
    import cifr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Watched ports
    input wire cifr_pkg::cifr_bus_req_t bus_req,
    input wire logic [7:0] bus_rdata,
    input wire cifr_pkg::cifr_src_t src_event,
    input wire cifr_pkg::cifr_src_t module_clear_pending,
    input wire cifr_pkg::cifr_src_t vector_ack,
    input wire cifr_pkg::cifr_src_t irq_request,
    input wire logic irq
);
    import cifr_pkg::*;

    cifr_src_t en;
    cifr_src_t msk;
    cifr_src_t hit;
    logic wr;
    assign wr = bus_req.wr;
    assign hit = src_event | module_clear_pending;
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            en <= 6'h00;
            msk <= 6'h00;
        end
        else if (wr && bus_req.addr == CIFR_OFS_ENABLE)
            en <= bus_req.wdata[5:0];
        else if (wr && bus_req.addr == CIFR_OFS_IMASK)
            msk <= bus_req.wdata[5:0];
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_reset_quiet: assert property ($past(rst) |-> !irq && !irq_request)
        else $error("outputs busy after reset");
    a_req_enable: assert property ((irq_request & ~$past(en)) == 6'h00)
        else $error("request without enable");
    a_event_req: assert property ((hit & en) != 6'h00 && !wr |->
        ##2 (irq_request & $past(hit & en, 2)) == $past(hit & en, 2))
        else $error("event gave no request");
    a_event_irq: assert property ((hit & msk) != 6'h00 && !wr |-> ##2 irq)
        else $error("event gave no irq");
    a_vector_clear: assert property (!wr && (vector_ack & ~hit & 6'h0f)
        != 6'h00 |-> ##2 (irq_request & $past(vector_ack, 2)) == 6'h00)
        else $error("vector left request up");
    a_pair_hold: assert property (!$past(wr) |=>
        ($past(irq_request) & ~irq_request & 6'h30) == 6'h00)
        else $error("pair request dropped");
    a_req_cause: assert property ($rose(irq_request[2]) |->
        $past(hit[2], 2) || $past(wr, 2))
        else $error("request rose without cause");
    a_irq_mask: assert property (irq |-> $past(msk) != 6'h00)
        else $error("irq with all masked");
endmodule
bind cifr_flags cifr_monitor cifr_monitor_inst (.sys_clk, .rst, .bus_req,
    .bus_rdata, .src_event, .module_clear_pending, .vector_ack,
    .irq_request, .irq);

//--- sim/cifr_cpu_model.sv
// Purpose: CPU vectoring model
// Assumes: Vectors only while go is high
// Notes: Gap lets the cleared request fall first
`timescale 1ns/1ps
module cifr_cpu_model
    import cifr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Vectoring
    input wire logic go,
    input wire cifr_pkg::cifr_src_t irq_request,
    output cifr_pkg::cifr_src_t vector_ack
);
    logic [1:0] gap;
    always_ff @(posedge sys_clk)
    begin
        vector_ack <= 6'h00;
        if (rst)
            gap <= 2'h0;
        else if (gap != 2'h0)
            gap <= gap - 2'h1;
        else if (go && irq_request != 6'h00)
        begin
            // Lowest source first, one-hot
            vector_ack <= irq_request & (~irq_request + 6'h01);
            gap <= 2'h3;
        end
    end
endmodule

//--- sim/cifr_flags_bench.sv
// Purpose: Self-checking bench for cifr_flags
// Assumes: Read data sampled two edges after rd
// Notes: Reads queue their expectation
`timescale 1ns/1ps
module cifr_flags_bench;
    import cifr_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    logic rd_d = 1'b0;
    cifr_bus_req_t bus_req = 18'h0;
    cifr_src_t src_event = 6'h00;
    cifr_src_t module_clear_pending = 6'h00;
    cifr_src_t vector_ack;
    cifr_src_t irq_request;
    logic [7:0] bus_rdata;
    logic irq;
    logic [7:0] exp_q[$];
    logic [7:0] f = 8'h05;
    logic [31:0] seed = 32'h58;
    int errors = 0;
    int compares = 0;
    cifr_flags cifr_flags_inst (.sys_clk, .rst, .bus_req, .bus_rdata,
        .src_event, .module_clear_pending, .vector_ack, .irq_request, .irq);
    cifr_cpu_model cifr_cpu_model_inst (.sys_clk, .rst, .go, .irq_request,
        .vector_ack);
    always #4 sys_clk = ~sys_clk;
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic check(logic [7:0] seen, logic [7:0] want);
        compares++;
        if (seen !== want)
        begin
            errors++;
            $display("mismatch %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
        if (!w)
            exp_q.push_back(d);
        bus_req <= '{a, w ? d : 8'h00, w, !w};
        @(posedge sys_clk);
        // Strobe is one cycle; a gap edge keeps one assignment per step
        bus_req <= 18'h0;
        @(posedge sys_clk);
    endtask
    task automatic idle(int n);
        bus_req <= 18'h0;
        src_event <= 6'h00;
        module_clear_pending <= 6'h00;
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic results();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        if (rd_d)
            check(bus_rdata, exp_q.pop_front());
        rd_d <= bus_req.rd;
    end
    initial
    begin
        #50000;
        errors++;
        results();
    end
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        acc(0, CIFR_OFS_FIRST, CIFR_RST_FIRST);
        acc(0, CIFR_OFS_CRYPTO, 8'h00);
        acc(0, CIFR_OFS_RADIO, 8'h00);
        acc(0, 8'h10, 8'h00);
        acc(1, CIFR_OFS_ENABLE, 8'h3f);
        acc(1, CIFR_OFS_IMASK, 8'h3f);
        for (int i = 0; i < 6; i++)
        begin
            src_event <= 6'h01 << i;
            @(posedge sys_clk);
            idle(3);
            f = i < 4 ? f | (8'h80 >> 2 * i) : f;
            acc(0, CIFR_OFS_FIRST, f);
        end
        acc(0, CIFR_OFS_CRYPTO, 8'h03);
        acc(0, CIFR_OFS_RADIO, 8'h03);
        idle(3);
        check({2'h0, irq_request}, 8'h3f);
        check({7'h00, irq}, 8'h01);
        go <= 1'b1;
        idle(24);
        go <= 1'b0;
        acc(0, CIFR_OFS_FIRST, 8'h05);
        acc(0, CIFR_OFS_CRYPTO, 8'h03);
        module_clear_pending <= 6'h02;
        @(posedge sys_clk);
        idle(3);
        acc(0, CIFR_OFS_FIRST, 8'h25);
        acc(1, CIFR_OFS_CRYPTO, 8'h00);
        acc(1, CIFR_OFS_RADIO, 8'h00);
        idle(3);
        check({2'h0, irq_request}, 8'h02);
        acc(1, CIFR_OFS_CRYPTO, 8'h01);
        acc(1, CIFR_OFS_RADIO, 8'h02);
        idle(3);
        check({2'h0, irq_request}, 8'h32);
        acc(1, CIFR_OFS_IMASK, 8'h00);
        idle(3);
        check({7'h00, irq}, 8'h00);
        acc(1, CIFR_OFS_IMASK, 8'h3f);
        idle(3);
        check({7'h00, irq}, 8'h01);
        acc(1, CIFR_OFS_ISTAT, 8'h3f);
        idle(3);
        check({7'h00, irq}, 8'h00);
        acc(1, CIFR_OFS_FIRST, 8'h55);
        acc(0, CIFR_OFS_FIRST, 8'h55);
        repeat (4)
        begin
            seed = xs(seed);
            acc(1, CIFR_OFS_CRYPTO, seed[7:0]);
            acc(0, CIFR_OFS_CRYPTO, seed[7:0]);
        end
        idle(4);
        results();
    end
endmodule
